// ---- hw/cab_params.svh ----
// Constants for the ALU, bit and skip block: offsets, field positions, resets
`ifndef CAB_PARAMS_SVH
`define CAB_PARAMS_SVH

// ==========================================================================
// Register offsets on the plain register port
// ==========================================================================
`define CAB_REG_ACC 2'h0
`define CAB_REG_STATUS 2'h1
`define CAB_REG_CTRL 2'h2
`define CAB_REG_RESULT 2'h3

// ==========================================================================
// Field positions
// ==========================================================================
`define CAB_STATUS_CARRY_BIT 0
`define CAB_STATUS_NIBBLE_BIT 1
`define CAB_STATUS_ZERO_BIT 2
`define CAB_CTRL_ENABLE_BIT 0

// ==========================================================================
// Reset values
// ==========================================================================
`define CAB_ACC_RST 8'h00
`define CAB_RESULT_RST 8'h00
`define CAB_FLAG_RST 1'h0
`define CAB_ENABLE_RST 1'h1
`define CAB_PINS_RST 8'h00

`endif

// ---- hw/cab_pkg.sv ----
// Types shared by the ALU, bit and skip block
`default_nettype none
package cab_pkg;

  // ========================================================================
  // Operation select from the instruction sequencer
  // ========================================================================
  typedef enum logic [2:0] {
    CAB_ADD_LITERAL_TO_ACC,
    CAB_AND_LITERAL_WITH_ACC,
    CAB_ADD_ACC_AND_FILE,
    CAB_AND_ACC_WITH_FILE,
    CAB_FILE_BIT_CLEAR_OP,
    CAB_FILE_BIT_SET_OP,
    CAB_SKIP_IF_BIT_ZERO_OP,
    CAB_IDLE_INSTRUCTION
  } cab_op_t;

  // ========================================================================
  // Execution state
  // ========================================================================
  typedef enum logic {
    CAB_ST_RUN,
    CAB_ST_SQUASH
  } cab_state_t;

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic nibble_carry;
    logic zero;
    logic enable;
    cab_state_t state;
    logic skip;
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    logic [7:0] result;
    logic [7:0] rdata;
  } cab_core_t;

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] stable;
  } cab_sync_t;

endpackage
`default_nettype wire

// ---- hw/cab_pin_sync.sv ----
// Two-flop synchroniser for the I/O port pin levels
`timescale 1ns/1ps
`default_nettype none
`include "cab_params.svh"

module cab_pin_sync (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] pins_i,
  output logic [7:0] pins_o
);
  import cab_pkg::*;

  cab_sync_t s_q;
  cab_sync_t s_d;

  // ========================================================================
  // First stage feeds only the second stage
  // ========================================================================
  always_comb begin
    s_d = s_q;
    s_d.meta = pins_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.meta <= `CAB_PINS_RST;
      s_q.stable <= `CAB_PINS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.stable;

endmodule
`default_nettype wire

// ---- hw/cab_alu_core.sv ----
// Accumulator ALU with bit set/clear and bit-test skip for the 8-bit core
// Summary of operation
// - Add-literal puts acc plus literal in acc; sets carry, nibble, zero.
// - AND-literal puts acc AND literal in acc; only zero changes.
// - Add-file adds acc and file reg 0 to 127; sets carry, nibble, zero.
// - AND-file ANDs acc with the file register; only zero changes.
// - File ops: destination 0 writes the acc, 1 writes the file register.
// - Bit clear zeroes the indexed bit of the file register; no flag moves.
// - Bit set forces the indexed bit of the file register to one; no flag.
// - Bit test lets the next op run when the bit is one; no flag changes.
// - A zero tested bit turns the fetched next op into an idle slot.
// - Read-modify-write of a port register reads pins, not the latch.
`timescale 1ns/1ps
`default_nettype none
`include "cab_params.svh"

module cab_alu_core (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Sequencer side
  input wire logic op_valid_i,
  input wire cab_pkg::cab_op_t op_code_i,
  input wire logic [6:0] file_addr_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic dest_file_i,
  input wire logic [7:0] literal_i,
  output logic skip_o,
  // File register space
  input wire logic [7:0] file_rdata_i,
  input wire logic file_is_port_i,
  input wire logic [7:0] port_pins_i,
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  // State
  output logic [7:0] acc_o,
  output logic carry_flag_o,
  output logic nibble_carry_flag_o,
  output logic zero_flag_o,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o
);
  import cab_pkg::*;

  cab_core_t s_q;
  cab_core_t s_d;
  logic [7:0] pins_sync;
  logic [7:0] operand;
  logic [7:0] res;
  logic [9:0] addv;
  logic run;
  logic squash;

  // ========================================================================
  // Helpers
  // ========================================================================
  // Returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [9:0] add_with_flags(input logic [7:0] a,
                                                input logic [7:0] b);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    add_with_flags = {full[8], lo[4], full[7:0]};
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // ========================================================================
  // Pin levels for port reads
  // ========================================================================
  // Pins are two cycles old when used; fine for software-paced port access
  cab_pin_sync u_pin_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pins_i(port_pins_i),
    .pins_o(pins_sync)
  );

  // ========================================================================
  // Read operand select
  // ========================================================================
  // The file write leaves one cycle late, so a back-to-back op on the
  // same address would read a stale value without this forward
  always_comb begin
    if (file_is_port_i) begin
      operand = pins_sync;
    end else if (s_q.file_we && (s_q.file_waddr == file_addr_i)) begin
      operand = s_q.file_wdata;
    end else begin
      operand = file_rdata_i;
    end
  end

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    s_d = s_q;
    s_d.file_we = 1'b0;
    s_d.skip = 1'b0;
    s_d.rdata = 8'h00;
    res = 8'h00;
    addv = 10'h000;
    run = op_valid_i && s_q.enable && (s_q.state == CAB_ST_RUN);
    squash = op_valid_i && s_q.enable && (s_q.state == CAB_ST_SQUASH);

    // Software writes first, so an op in the same cycle wins
    if (reg_we_i) begin
      if (reg_addr_i == `CAB_REG_ACC) begin
        s_d.acc = reg_wdata_i;
      end else if (reg_addr_i == `CAB_REG_STATUS) begin
        s_d.carry = reg_wdata_i[`CAB_STATUS_CARRY_BIT];
        s_d.nibble_carry = reg_wdata_i[`CAB_STATUS_NIBBLE_BIT];
        s_d.zero = reg_wdata_i[`CAB_STATUS_ZERO_BIT];
      end else if (reg_addr_i == `CAB_REG_CTRL) begin
        s_d.enable = reg_wdata_i[`CAB_CTRL_ENABLE_BIT];
      end
    end

    if (reg_re_i) begin
      if (reg_addr_i == `CAB_REG_ACC) begin
        s_d.rdata = s_q.acc;
      end else if (reg_addr_i == `CAB_REG_STATUS) begin
        s_d.rdata[`CAB_STATUS_CARRY_BIT] = s_q.carry;
        s_d.rdata[`CAB_STATUS_NIBBLE_BIT] = s_q.nibble_carry;
        s_d.rdata[`CAB_STATUS_ZERO_BIT] = s_q.zero;
      end else if (reg_addr_i == `CAB_REG_CTRL) begin
        s_d.rdata[`CAB_CTRL_ENABLE_BIT] = s_q.enable;
      end else if (reg_addr_i == `CAB_REG_RESULT) begin
        s_d.rdata = s_q.result;
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // Discarded slot: the fetched op has no effect at all
    if (squash) begin
      s_d.state = CAB_ST_RUN;
    end

    if (run) begin
      case (op_code_i)
        CAB_ADD_LITERAL_TO_ACC: begin
          addv = add_with_flags(s_q.acc, literal_i);
          res = addv[7:0];
          s_d.acc = res;
          s_d.carry = addv[9];
          s_d.nibble_carry = addv[8];
          s_d.zero = is_zero(res);
          s_d.result = res;
        end
        CAB_AND_LITERAL_WITH_ACC: begin
          res = s_q.acc & literal_i;
          s_d.acc = res;
          s_d.zero = is_zero(res);
          s_d.result = res;
        end
        CAB_ADD_ACC_AND_FILE: begin
          addv = add_with_flags(s_q.acc, operand);
          res = addv[7:0];
          s_d.carry = addv[9];
          s_d.nibble_carry = addv[8];
          s_d.zero = is_zero(res);
          s_d.result = res;
          if (dest_file_i) begin
            s_d.file_we = 1'b1;
            s_d.file_waddr = file_addr_i;
            s_d.file_wdata = res;
          end else begin
            s_d.acc = res;
          end
        end
        CAB_AND_ACC_WITH_FILE: begin
          res = s_q.acc & operand;
          s_d.zero = is_zero(res);
          s_d.result = res;
          if (dest_file_i) begin
            s_d.file_we = 1'b1;
            s_d.file_waddr = file_addr_i;
            s_d.file_wdata = res;
          end else begin
            s_d.acc = res;
          end
        end
        CAB_FILE_BIT_CLEAR_OP: begin
          res = operand & ~bit_mask(bit_idx_i);
          s_d.file_we = 1'b1;
          s_d.file_waddr = file_addr_i;
          s_d.file_wdata = res;
          s_d.result = res;
        end
        CAB_FILE_BIT_SET_OP: begin
          res = operand | bit_mask(bit_idx_i);
          s_d.file_we = 1'b1;
          s_d.file_waddr = file_addr_i;
          s_d.file_wdata = res;
          s_d.result = res;
        end
        CAB_SKIP_IF_BIT_ZERO_OP: begin
          // Bit one: fall through, flags untouched
          if ((operand & bit_mask(bit_idx_i)) == 8'h00) begin
            s_d.state = CAB_ST_SQUASH;
            s_d.skip = 1'b1;
          end else begin
            s_d.state = CAB_ST_RUN;
          end
        end
        default: begin
          s_d.state = CAB_ST_RUN;
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.acc <= `CAB_ACC_RST;
      s_q.carry <= `CAB_FLAG_RST;
      s_q.nibble_carry <= `CAB_FLAG_RST;
      s_q.zero <= `CAB_FLAG_RST;
      s_q.enable <= `CAB_ENABLE_RST;
      s_q.state <= CAB_ST_RUN;
      s_q.skip <= 1'b0;
      s_q.file_we <= 1'b0;
      s_q.file_waddr <= 7'h00;
      s_q.file_wdata <= 8'h00;
      s_q.result <= `CAB_RESULT_RST;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign skip_o = s_q.skip;
  assign file_we_o = s_q.file_we;
  assign file_waddr_o = s_q.file_waddr;
  assign file_wdata_o = s_q.file_wdata;
  assign acc_o = s_q.acc;
  assign carry_flag_o = s_q.carry;
  assign nibble_carry_flag_o = s_q.nibble_carry;
  assign zero_flag_o = s_q.zero;
  assign reg_rdata_o = s_q.rdata;

endmodule
`default_nettype wire

// ---- verification/cab_file_model.sv ----
// File register space model facing the ALU block
`timescale 1ns/1ps
`default_nettype none
module cab_file_model (
  input wire logic mclk_i,
  input wire logic [6:0] addr_i,
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic is_port_o
);
  // ==========================================================
  // Storage, written one edge after the op, so reuse relies on
  // the block forwarding its own pending write
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37);
    end
  end
  always @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem[addr_i];
  assign is_port_o = (addr_i == 7'h05);
endmodule
`default_nettype wire

// ---- verification/cab_alu_sva.sv ----
// Assertion checker for the ALU, bit and skip block
`timescale 1ns/1ps
`default_nettype none
module cab_alu_sva (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic op_valid_i,
  input wire cab_pkg::cab_op_t op_code_i,
  input wire logic [6:0] file_addr_i,
  input wire logic [2:0] bit_idx_i,
  input wire logic dest_file_i,
  input wire logic [7:0] literal_i,
  input wire logic skip_o,
  input wire logic [7:0] file_rdata_i,
  input wire logic file_is_port_i,
  input wire logic file_we_o,
  input wire logic [6:0] file_waddr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] acc_o,
  input wire logic carry_flag_o,
  input wire logic nibble_carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i
);
  import cab_pkg::*;
  logic en_q, sq_q, squash, taken, lit, is_add, is_and, dst;
  logic cy, nc, bz;
  logic [7:0] opnd, b, bm, res, clr_v, set_v;
  logic [8:0] sum;
  logic [4:0] nib;
  // ==========================================================
  // Enable and squash window; port operands left to the bench
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b1;
      sq_q <= 1'b0;
    end else begin
      if (reg_we_i && reg_addr_i == 2'h2) begin
        en_q <= reg_wdata_i[0];
      end
      // Only a slot that the block would accept ends the discard window
      sq_q <= squash & ~(op_valid_i & en_q);
    end
  end
  assign squash = skip_o | sq_q;
  assign taken = op_valid_i & en_q & ~squash & ~file_is_port_i;
  assign lit = op_code_i inside {CAB_ADD_LITERAL_TO_ACC,
                                 CAB_AND_LITERAL_WITH_ACC};
  assign is_add = op_code_i inside {CAB_ADD_LITERAL_TO_ACC,
                                    CAB_ADD_ACC_AND_FILE};
  assign is_and = op_code_i inside {CAB_AND_LITERAL_WITH_ACC,
                                    CAB_AND_ACC_WITH_FILE};
  assign dst = dest_file_i & ~lit;
  assign opnd = (file_we_o && file_waddr_o == file_addr_i) ?
                file_wdata_o : file_rdata_i;
  assign b = lit ? literal_i : opnd;
  assign sum = {1'b0, acc_o} + {1'b0, b};
  assign nib = {1'b0, acc_o[3:0]} + {1'b0, b[3:0]};
  assign res = is_add ? sum[7:0] : (acc_o & b);
  assign bm = 8'h01 << bit_idx_i;
  assign cy = sum[8];
  assign nc = nib[4];
  assign bz = (opnd & bm) == 8'h00;
  assign clr_v = opnd & ~bm;
  assign set_v = opnd | bm;
  // ==========================================================
  // Assertions
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence flags_held;
    $stable(carry_flag_o) && $stable(nibble_carry_flag_o) &&
    $stable(zero_flag_o);
  endsequence
  sequence squashed_slot;
    squash && op_valid_i && !reg_we_i;
  endsequence
  dest_sel_a:
    assert property (taken && (is_add || is_and) |=> file_we_o == $past(dst)
      && (file_we_o ? file_wdata_o == $past(res) : acc_o == $past(res)))
    else $error("result went to the wrong place");
  add_flags_a:
    assert property (taken && is_add |=> carry_flag_o == $past(cy) &&
      nibble_carry_flag_o == $past(nc))
    else $error("add carry flags wrong");
  zero_flag_a:
    assert property (taken && (is_add || is_and) |=>
      zero_flag_o == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  and_flags_a:
    assert property (taken && is_and && !reg_we_i |=> $stable(carry_flag_o) &&
      $stable(nibble_carry_flag_o))
    else $error("logic op touched carry");
  bit_clear_a:
    assert property (taken && !reg_we_i &&
      op_code_i == CAB_FILE_BIT_CLEAR_OP |=>
      (file_we_o && file_wdata_o == $past(clr_v)) ##0 flags_held)
    else $error("bit clear wrong");
  bit_set_a:
    assert property (taken && !reg_we_i &&
      op_code_i == CAB_FILE_BIT_SET_OP |=>
      (file_we_o && file_waddr_o == $past(file_addr_i) &&
      file_wdata_o == $past(set_v)) ##0 flags_held)
    else $error("bit set wrong");
  skip_test_a:
    assert property (taken && !reg_we_i &&
      op_code_i == CAB_SKIP_IF_BIT_ZERO_OP |=>
      (skip_o == $past(bz)) ##0 flags_held)
    else $error("skip decision wrong");
  squash_a:
    assert property (squashed_slot |=> (!file_we_o && !skip_o &&
      $stable(acc_o)) ##0 flags_held)
    else $error("discarded slot had an effect");
endmodule
bind cab_alu_core cab_alu_sva u_sva (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
  .op_code_i(op_code_i), .file_addr_i(file_addr_i),
  .bit_idx_i(bit_idx_i), .dest_file_i(dest_file_i),
  .literal_i(literal_i), .skip_o(skip_o), .file_rdata_i(file_rdata_i),
  .file_is_port_i(file_is_port_i), .file_we_o(file_we_o),
  .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
  .acc_o(acc_o), .carry_flag_o(carry_flag_o),
  .nibble_carry_flag_o(nibble_carry_flag_o), .zero_flag_o(zero_flag_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the ALU, bit and skip block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cab_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, op_valid_i = 1'b0;
  cab_op_t op_code_i = CAB_IDLE_INSTRUCTION;
  logic [6:0] file_addr_i = 7'h00, file_waddr_o;
  logic [2:0] bit_idx_i = 3'h0;
  logic [1:0] reg_addr_i = 2'h0;
  logic dest_file_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic [7:0] literal_i = 8'h00, port_pins_i = 8'h00, reg_wdata_i = 8'h00;
  logic skip_o, file_we_o, file_is_port_i;
  logic carry_flag_o, nibble_carry_flag_o, zero_flag_o;
  logic [7:0] file_wdata_o, file_rdata_i, acc_o, reg_rdata_o;
  logic [31:0] x;
  int err_total = 0, n_tests = 0, mem [128], sq, tk, b, bm, r, op, nf;
  int m_acc, m_f, m_en, m_sq, m_skp, m_we, m_wa, m_wd, m_rd, m_res, m_p1, m_p2;
  always #2.5 mclk_i = ~mclk_i;
  cab_alu_core dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .file_addr_i(file_addr_i),
    .bit_idx_i(bit_idx_i), .dest_file_i(dest_file_i),
    .literal_i(literal_i), .skip_o(skip_o), .file_rdata_i(file_rdata_i),
    .file_is_port_i(file_is_port_i), .port_pins_i(port_pins_i),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o),
    .nibble_carry_flag_o(nibble_carry_flag_o), .zero_flag_o(zero_flag_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));
  cab_file_model u_file (.mclk_i, .addr_i(file_addr_i), .we_i(file_we_o),
    .waddr_i(file_waddr_o), .wdata_i(file_wdata_o),
    .rdata_o(file_rdata_i), .is_port_o(file_is_port_i));
  initial for (int i = 0; i < 128; i++) mem[i] = (i * 37) & 255;
  // ==========================================================
  // Reference model, sampled on the same edge as the design
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {m_acc, m_f, m_sq, m_skp, m_we, m_rd, m_res, m_p1, m_p2} = '0;
      m_en = 1;
    end else begin
      op = int'(op_code_i);
      sq = m_skp | m_sq;
      tk = op_valid_i && m_en && !sq;
      // A disabled slot does not end the discard window
      m_sq = sq && !(op_valid_i && m_en);
      {m_skp, m_we, m_rd} = '0;
      b = op < 2 ? literal_i : file_is_port_i ? m_p2 : mem[file_addr_i];
      bm = 1 << bit_idx_i;
      r = op[0] ? (op < 4 ? m_acc & b : b | bm) :
          (op < 4 ? m_acc + b : b & ~bm);
      nf = (((m_acc & 15) + (b & 15)) >> 3 & 2) | r >> 8;
      // Reads see the old state; an op beats a software write
      if (reg_re_i) m_rd = reg_addr_i == 0 ? m_acc : reg_addr_i == 1 ? m_f :
                          reg_addr_i == 2 ? m_en : m_res;
      if (reg_we_i && reg_addr_i == 0) m_acc = reg_wdata_i;
      if (reg_we_i && reg_addr_i == 1) m_f = reg_wdata_i & 7;
      if (reg_we_i && reg_addr_i == 2) m_en = reg_wdata_i & 1;
      if (tk && op < 6) begin
        m_res = r & 255;
        if (op < 4) begin
          m_f = op[0] ? m_f & 3 : nf;
          m_f = m_f | ((r & 255) == 0) << 2;
        end
        if (op > 1 && (op > 3 || dest_file_i)) begin
          m_we = 1;
          m_wa = int'(file_addr_i);
          m_wd = r & 255;
          mem[file_addr_i] = r & 255;
        end else m_acc = r & 255;
      end
      if (tk && op == 6) m_skp = (b & bm) == 0;
      {m_p2, m_p1} = {m_p1, int'(port_pins_i)};
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(negedge mclk_i) begin
    if (reset_n_i) begin
      chk(acc_o, 8'(m_acc));
      chk({5'h00, zero_flag_o, nibble_carry_flag_o, carry_flag_o}, 8'(m_f));
      chk({7'h00, skip_o}, 8'(m_skp));
      chk({7'h00, file_we_o}, 8'(m_we));
      if (m_we) chk({1'b0, file_waddr_o}, 8'(m_wa));
      if (m_we) chk(file_wdata_o, 8'(m_wd));
      chk(reg_rdata_o, 8'(m_rd));
    end
  end
  // ==========================================================
  // Stimulus
  task automatic regop(input logic we, re, input logic [1:0] a,
                       input logic [7:0] d);
    @(posedge mclk_i);
    {reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= {we, re, a, d};
    // Strobes last one cycle only
    @(posedge mclk_i);
    {reg_we_i, reg_re_i} <= 2'b00;
  endtask
  task automatic run_ops(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      x = $urandom;
      op_valid_i <= x[1:0] != 2'h0;
      op_code_i <= cab_op_t'(x[4:2]);
      file_addr_i <= x[8] ? x[15:9] : {5'h01, x[10:9]};
      {dest_file_i, bit_idx_i, literal_i} <= x[27:16];
      if (i % 8 == 0) port_pins_i <= 8'($urandom);
    end
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    void'($urandom(32'h89E6));
    for (int a = 0; a < 4; a++) regop(1'b0, 1'b1, 2'(a), 8'h00);
    run_ops(500);
    regop(1'b1, 1'b0, 2'h0, 8'hFF);
    regop(1'b1, 1'b0, 2'h1, 8'h07);
    regop(1'b1, 1'b0, 2'h3, 8'h5A);
    for (int a = 0; a < 4; a++) regop(1'b0, 1'b1, 2'(a), 8'h00);
    regop(1'b1, 1'b0, 2'h2, 8'h00);
    regop(1'b0, 1'b0, 2'h0, 8'h00);
    run_ops(40);
    regop(1'b1, 1'b1 ^ 1'b1, 2'h2, 8'h01);
    regop(1'b0, 1'b0, 2'h0, 8'h00);
    run_ops(300);
    repeat (4) @(posedge mclk_i);
    final_report();
  end
endmodule
`default_nettype wire
